/* design/fifo_interlock_pkg.sv */
// Shared constants, types and register map for the FIFO slice interlock block.
package fifo_interlock_pkg;

  // Word width of one slice and index of the last serial shift of a word.
  localparam int unsigned SLICE_W = 4;
  localparam logic [2:0]  SHIFT_LAST = 3'h3;

  // Reference clock period in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 100;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFF_OUT_WORD = 8'h10;

  // Control register fields and reset value.
  localparam int unsigned CTRL_IN_EN_BIT  = 0;
  localparam int unsigned CTRL_OUT_EN_BIT = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h3;

  // Status register field positions.
  localparam int unsigned ST_MASTER_BIT  = 0;
  localparam int unsigned ST_IN_FULL_BIT = 1;
  localparam int unsigned ST_OUT_EMP_BIT = 2;
  localparam int unsigned ST_REQ_INIT    = 3;
  localparam int unsigned ST_OUT_REQ     = 4;

  // Interrupt event bits, same layout in status and mask.
  localparam int unsigned IRQ_W         = 3;
  localparam int unsigned EV_PUSHED     = 0;
  localparam int unsigned EV_IN_FULL    = 1;
  localparam int unsigned EV_OUT_LOADED = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  // AHB transfer type encodings used by the slave.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Input register: four data bits plus the fill marker at the output end.
  typedef struct packed {
    logic [SLICE_W-1:0] data;
    logic               fill_marker_bit;
  } in_reg_t;

  // Initialized input register: marker one in the top data bit, rest clear.
  localparam in_reg_t IN_REG_INIT = '{data: 4'h8, fill_marker_bit: 1'b0};

  // Output register progress, Gray coded along empty, pending, full.
  typedef enum logic [1:0] {
    OUT_EMPTY   = 2'b00,
    OUT_PENDING = 2'b01,
    OUT_FULL    = 2'b11
  } out_state_t;

  // Slice chain pins grouped as they arrive.
  typedef struct packed {
    logic init_clear_n;
    logic serial_in_chain_enable_n;
    logic serial_out_chain_enable_n;
    logic stack_push_request_n;
    logic serial_unload_request_n;
    logic parallel_unload;
    logic parallel_load_strobe;
    logic serial_in_shift_clock;
    logic serial_out_shift_clock;
    logic serial_in_bit;
  } chain_in_t;

endpackage : fifo_interlock_pkg

/* design/fifo_array_interlock.sv */
// FIFO slice input/output registers with master/slave array interlock and AHB-Lite registers.
// Notes on behaviour
// (R1) Slices tile into (15m+1) words by 4n bits with no external gating.
// (R2) Slave re-initializes input register only after serial input chain enable goes low.
// (R3) Slave output-empty flag rises only after output chain enable went high.
// (R4) Writer waits for last slave input-full low; reader waits output-empty high.
// (R5) Master has chain enable tied low; slaves fed by previous input-full.
// (R6) During init clear every slice drives input-full flag high.
// (R7) Master latch sets while init clear and serial input enable both low.
// (R8) Low stack push request sets the request-initialization flip-flop.
// (R9) Master with pending request re-initializes at once and clears request.
// (R10) Non-master pending request waits for serial input enable low.
// (R11) Push request ripples re-initialization from row master down the slaves.
// (R12) Serial or parallel unload starts stack load and sets output request.
// (R13) Master completing load sets last output bit; output-empty flag goes high.
// (R14) Slave keeps output-empty low after load until output chain enable arrives.
// (R15) Serial bits shift on falling clock; after fourth, marker sets, clocks ignored.
// (R16) Re-initialization after stack transfer waits until parallel load returns low.
// (R17) Most significant slice flags drive all push and unload requests of a row.
// (R18) Master latch holds its value after init clear releases.
// (R19) Init clear empties both request flip-flops.
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
module fifo_array_interlock (
  // Clock and reset.
  input  wire logic                                     i_ref_clk,
  input  wire logic                                     i_rst,
  // Slice chain pins.
  input  wire fifo_interlock_pkg::chain_in_t            i_chain,
  input  wire logic [fifo_interlock_pkg::SLICE_W-1:0]   i_data,
  output logic                                          o_input_full_flag_n,
  output logic                                          o_output_empty_flag_n,
  output logic [fifo_interlock_pkg::SLICE_W-1:0]        o_data,
  output logic                                          o_serial_out_bit,
  output logic                                          o_serial_out_oe,
  // Stack side: top entry and bottom exit.
  input  wire logic                                     i_stack_top_free,
  output logic                                          o_stack_push,
  output logic [fifo_interlock_pkg::SLICE_W-1:0]        o_stack_word,
  input  wire logic                                     i_stack_bottom_valid,
  input  wire logic [fifo_interlock_pkg::SLICE_W-1:0]   i_stack_bottom_word,
  output logic                                          o_stack_pop,
  // AHB-Lite slave.
  input  wire logic                                     i_hsel,
  input  wire logic [7:0]                               i_haddr,
  input  wire logic [1:0]                               i_htrans,
  input  wire logic                                     i_hwrite,
  input  wire logic [2:0]                               i_hsize,
  input  wire logic [31:0]                              i_hwdata,
  input  wire logic                                     i_hready,
  output logic [31:0]                                   o_hrdata,
  output logic                                          o_hreadyout,
  output logic                                          o_hresp,
  // Interrupt.
  output logic                                          o_irq
);

  // Slice state.
  fifo_interlock_pkg::in_reg_t    in_reg_q, in_reg_d;
  fifo_interlock_pkg::out_state_t out_st_q, out_st_d;
  logic                           master_q, master_d;
  logic                           req_init_q, req_init_d;
  logic [3:0]                     out_word_q, out_word_d;
  logic [2:0]                     out_cnt_q, out_cnt_d;
  logic                           sin_clk_prev_q, sout_clk_prev_q, top_prev_q;
  logic                           push_q, push_d, pop_q, pop_d;
  logic [3:0]                     stack_word_q, stack_word_d;

  // Bus and interrupt state.
  logic [1:0]                     ctrl_q, ctrl_d;
  logic [2:0]                     irq_stat_q, irq_stat_d;
  logic [2:0]                     irq_mask_q, irq_mask_d;
  logic                           wr_pend_q, wr_pend_d;
  logic [7:0]                     wr_addr_q, wr_addr_d;
  logic [31:0]                    hrdata_q, hrdata_d;
  logic                           irq_q, irq_d;

  // Decoded strobes.
  logic                           sin_fall, sout_fall, top_fall;
  logic                           in_en, out_en, unload_req;
  logic [2:0]                     events;
  logic [31:0]                    status_word;

  // Falling edges of the sampled shift clocks and of the parallel unload level.
  assign sin_fall  = sin_clk_prev_q & ~i_chain.serial_in_shift_clock;
  assign sout_fall = sout_clk_prev_q & ~i_chain.serial_out_shift_clock;
  assign top_fall  = top_prev_q & ~i_chain.parallel_unload;
  assign in_en     = ctrl_q[fifo_interlock_pkg::CTRL_IN_EN_BIT];
  assign out_en    = ctrl_q[fifo_interlock_pkg::CTRL_OUT_EN_BIT];
  assign unload_req = ~i_chain.serial_unload_request_n | i_chain.parallel_unload;

  // Input side: master latch, shift or parallel entry, push and re-initialization.
  always_comb begin
    master_d     = master_q;
    in_reg_d     = in_reg_q;
    req_init_d   = req_init_q;
    push_d       = 1'b0;
    stack_word_d = stack_word_q;
    if (!i_chain.init_clear_n) begin
      // Role is decided only while init clear is held; it sticks afterwards.
      master_d   = ~i_chain.serial_in_chain_enable_n; // R7 R18
      in_reg_d   = fifo_interlock_pkg::IN_REG_INIT; // R6
      req_init_d = 1'b0; // R19
    end else begin
      if (in_en && i_chain.parallel_load_strobe) begin
        in_reg_d.data            = i_data;
        in_reg_d.fill_marker_bit = 1'b1;
      end else if (in_en && sin_fall && !i_chain.serial_in_chain_enable_n &&
                   !in_reg_q.fill_marker_bit) begin
        // Marker rides down ahead of the shifted-in data and blocks clocks once it lands.
        in_reg_d = {i_chain.serial_in_bit, in_reg_q.data}; // R15
      end
      if (!i_chain.stack_push_request_n && in_reg_q.fill_marker_bit && !req_init_q &&
          i_stack_top_free) begin
        push_d       = 1'b1;
        stack_word_d = in_reg_q.data;
        req_init_d   = 1'b1; // R8
      end
      // A slave waits for the slice above; this ripples down the row.
      if (req_init_q && !i_chain.parallel_load_strobe &&
          (master_q || !i_chain.serial_in_chain_enable_n)) begin // R1 R2 R9 R10 R11 R16
        in_reg_d   = fifo_interlock_pkg::IN_REG_INIT;
        req_init_d = 1'b0; // R9
      end
    end
  end

  // Input side registers.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      master_q       <= 1'b0;
      in_reg_q       <= fifo_interlock_pkg::IN_REG_INIT;
      req_init_q     <= 1'b0;
      push_q         <= 1'b0;
      stack_word_q   <= 4'h0;
      sin_clk_prev_q <= 1'b0;
      o_input_full_flag_n <= 1'b1;
    end else begin
      master_q       <= master_d;
      in_reg_q       <= in_reg_d;
      req_init_q     <= req_init_d;
      push_q         <= push_d;
      stack_word_q   <= stack_word_d;
      sin_clk_prev_q <= i_chain.serial_in_shift_clock;
      // Flag pin is its own flop, fed from the next marker so it keeps the same timing.
      o_input_full_flag_n <= ~in_reg_d.fill_marker_bit; // R6
    end
  end

  // Output side: load from stack, interlocked release, serial or parallel drain.
  always_comb begin
    out_st_d   = out_st_q;
    out_word_d = out_word_q;
    out_cnt_d  = out_cnt_q;
    pop_d      = 1'b0;
    if (!i_chain.init_clear_n) begin
      out_st_d  = fifo_interlock_pkg::OUT_EMPTY; // R19
      out_cnt_d = 3'h0;
    end else begin
      case (out_st_q)
        fifo_interlock_pkg::OUT_EMPTY: begin
          // Level sensitive request; the state guard stops a double transfer.
          if (out_en && unload_req && i_stack_bottom_valid) begin // R12
            out_word_d = i_stack_bottom_word;
            out_cnt_d  = 3'h0;
            pop_d      = 1'b1;
            out_st_d   = fifo_interlock_pkg::OUT_PENDING; // R12
          end
        end
        fifo_interlock_pkg::OUT_PENDING: begin
          if (master_q || i_chain.serial_out_chain_enable_n) begin // R3 R13 R14
            out_st_d = fifo_interlock_pkg::OUT_FULL; // R13
          end
        end
        fifo_interlock_pkg::OUT_FULL: begin
          if (top_fall) begin
            out_st_d = fifo_interlock_pkg::OUT_EMPTY;
          end else if (sout_fall) begin
            out_word_d = {1'b0, out_word_q[3:1]};
            out_cnt_d  = out_cnt_q + 3'h1;
            if (out_cnt_q == fifo_interlock_pkg::SHIFT_LAST) begin
              out_st_d = fifo_interlock_pkg::OUT_EMPTY;
            end
          end
        end
        default: begin
          out_st_d = fifo_interlock_pkg::OUT_EMPTY;
        end
      endcase
    end
  end

  // Output side registers.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      out_st_q        <= fifo_interlock_pkg::OUT_EMPTY;
      out_word_q      <= 4'h0;
      out_cnt_q       <= 3'h0;
      pop_q           <= 1'b0;
      sout_clk_prev_q <= 1'b0;
      top_prev_q      <= 1'b0;
      o_output_empty_flag_n <= 1'b0;
      o_serial_out_oe <= 1'b0;
    end else begin
      out_st_q        <= out_st_d;
      out_word_q      <= out_word_d;
      out_cnt_q       <= out_cnt_d;
      pop_q           <= pop_d;
      sout_clk_prev_q <= i_chain.serial_out_shift_clock;
      top_prev_q      <= i_chain.parallel_unload;
      o_output_empty_flag_n <= (out_st_d == fifo_interlock_pkg::OUT_FULL); // R13
      o_serial_out_oe <= (out_st_d == fifo_interlock_pkg::OUT_FULL);
    end
  end

  // Pins follow the registered state directly; the flags have flops of their own.
  assign o_data                = out_word_q;
  assign o_serial_out_bit      = out_word_q[0];
  assign o_stack_push          = push_q;
  assign o_stack_word          = stack_word_q;
  assign o_stack_pop           = pop_q;

  // Events that raise sticky interrupt bits.
  always_comb begin
    events = 3'h0;
    events[fifo_interlock_pkg::EV_PUSHED]     = push_q;
    events[fifo_interlock_pkg::EV_IN_FULL]    = in_reg_d.fill_marker_bit &
                                                ~in_reg_q.fill_marker_bit;
    events[fifo_interlock_pkg::EV_OUT_LOADED] = (out_st_d == fifo_interlock_pkg::OUT_FULL) &&
                                                (out_st_q != fifo_interlock_pkg::OUT_FULL);
  end

  // Live status word.
  always_comb begin
    status_word = 32'h0;
    status_word[fifo_interlock_pkg::ST_MASTER_BIT]  = master_q;
    status_word[fifo_interlock_pkg::ST_IN_FULL_BIT] = in_reg_q.fill_marker_bit;
    status_word[fifo_interlock_pkg::ST_OUT_EMP_BIT] = (out_st_q == fifo_interlock_pkg::OUT_FULL);
    status_word[fifo_interlock_pkg::ST_REQ_INIT]    = req_init_q;
    status_word[fifo_interlock_pkg::ST_OUT_REQ]     =
      (out_st_q == fifo_interlock_pkg::OUT_PENDING);
  end

  // Bus slave: zero wait states; writes land in the data phase, reads are
  // fetched in the address phase so hrdata comes straight from a flop.
  always_comb begin
    ctrl_d     = ctrl_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    wr_pend_d  = wr_pend_q;
    wr_addr_d  = wr_addr_q;
    hrdata_d   = hrdata_q;
    if (wr_pend_q) begin
      if (wr_addr_q == fifo_interlock_pkg::OFF_CTRL) begin
        ctrl_d = i_hwdata[1:0];
      end else if (wr_addr_q == fifo_interlock_pkg::OFF_IRQ_MASK) begin
        irq_mask_d = i_hwdata[2:0];
      end else if (wr_addr_q == fifo_interlock_pkg::OFF_IRQ_STAT) begin
        irq_stat_d = irq_stat_q & ~i_hwdata[2:0];
      end
    end
    // A fresh event beats a clear written in the same cycle.
    irq_stat_d = irq_stat_d | events;
    if (i_hready) begin
      wr_pend_d = i_hsel && (i_htrans == fifo_interlock_pkg::HTRANS_NONSEQ) && i_hwrite;
      wr_addr_d = i_haddr;
      if (i_hsel && (i_htrans == fifo_interlock_pkg::HTRANS_NONSEQ) && !i_hwrite) begin
        if (i_haddr == fifo_interlock_pkg::OFF_CTRL) begin
          hrdata_d = {30'h0, ctrl_q};
        end else if (i_haddr == fifo_interlock_pkg::OFF_STATUS) begin
          hrdata_d = status_word;
        end else if (i_haddr == fifo_interlock_pkg::OFF_IRQ_STAT) begin
          hrdata_d = {29'h0, irq_stat_q};
        end else if (i_haddr == fifo_interlock_pkg::OFF_IRQ_MASK) begin
          hrdata_d = {29'h0, irq_mask_q};
        end else if (i_haddr == fifo_interlock_pkg::OFF_OUT_WORD) begin
          hrdata_d = {28'h0, out_word_q};
        end else begin
          hrdata_d = 32'h0;
        end
      end
    end
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  // Bus and interrupt registers.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q      <= fifo_interlock_pkg::CTRL_RESET;
      irq_mask_q  <= fifo_interlock_pkg::IRQ_MASK_RESET;
      irq_stat_q  <= 3'h0;
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 8'h00;
      hrdata_q    <= 32'h0;
      irq_q       <= 1'b0;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      ctrl_q      <= ctrl_d;
      irq_mask_q  <= irq_mask_d;
      irq_stat_q  <= irq_stat_d;
      wr_pend_q   <= wr_pend_d;
      wr_addr_q   <= wr_addr_d;
      hrdata_q    <= hrdata_d;
      irq_q       <= irq_d;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end

  assign o_hrdata = hrdata_q;
  assign o_irq    = irq_q;

endmodule // fifo_array_interlock

/* tb/fifo_array_interlock_monitor.sv */
// Assertion checker watching the ports of the FIFO slice interlock block.
module fifo_array_interlock_monitor (
  // Clock and reset.
  input wire logic                          i_ref_clk,
  input wire logic                          i_rst,
  // Watched inputs and outputs.
  input wire fifo_interlock_pkg::chain_in_t i_chain,
  input wire logic                          i_stack_top_free,
  input wire logic                          i_stack_bottom_valid,
  input wire logic                          o_input_full_flag_n,
  input wire logic                          o_output_empty_flag_n,
  input wire logic                          o_stack_push,
  input wire logic                          o_stack_pop
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic master_q;
  logic master_d;
  // The role is copied only while init clear is low, so it cannot drift in mid-run.
  always_comb begin
    master_d = master_q;
    if (!i_chain.init_clear_n) master_d = !i_chain.serial_in_chain_enable_n;
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) master_q <= 1'h0;
    else master_q <= master_d;
  end
  a_init_flag_high: assert property (!i_chain.init_clear_n |=> o_input_full_flag_n)
    else $error("input full flag low after init clear");
  a_push_cause: assert property (o_stack_push |-> !$past(i_chain.stack_push_request_n)
    && !$past(o_input_full_flag_n) && $past(i_stack_top_free))
    else $error("push without cause");
  a_push_single: assert property (o_stack_push |=> !o_stack_push)
    else $error("same word pushed twice");
  a_reinit_wait: assert property ($rose(o_input_full_flag_n)
    && $past(i_chain.init_clear_n) |-> !$past(i_chain.parallel_load_strobe)
    && ($past(master_q) || !$past(i_chain.serial_in_chain_enable_n)))
    else $error("input register cleared too early");
  a_master_out_ready: assert property (o_stack_pop && master_q && i_chain.init_clear_n
    |=> o_output_empty_flag_n) else $error("master output flag late");
  a_slave_out_wait: assert property ($rose(o_output_empty_flag_n) && !master_q
    |-> $past(i_chain.serial_out_chain_enable_n)) else $error("slave output flag early");
  a_pop_cause: assert property (o_stack_pop |-> (!$past(i_chain.serial_unload_request_n)
    || $past(i_chain.parallel_unload)) && $past(i_stack_bottom_valid)
    && !$past(o_output_empty_flag_n)) else $error("pop without cause");
  a_fill_cause: assert property ($fell(o_input_full_flag_n)
    |-> $past(i_chain.parallel_load_strobe)
    || ($past(i_chain.serial_in_shift_clock, 2) && !$past(i_chain.serial_in_shift_clock)))
    else $error("input filled without load or shift");
endmodule // fifo_array_interlock_monitor

/* tb/stack_model.sv */
// Behavioural stack neighbour: a one-word store fed by pushes and drained by pops.
module stack_model (
  // Clock, reset and slow-down control.
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_stall,
  // Slice side.
  input  wire logic       i_push,
  input  wire logic [3:0] i_word,
  input  wire logic       i_pop,
  output logic            o_top_free,
  output logic            o_bottom_valid,
  output logic [3:0]      o_bottom_word,
  // Observation for the bench.
  output logic [3:0]      o_last_word,
  output int              o_pushes
);
  timeunit 1ns;
  timeprecision 1ns;
  // A stall refuses the top entry, as a slow fall-through would.
  assign o_top_free = !o_bottom_valid && !i_stall;
  // An empty store shows the inverse word so no stale copy can pass for data.
  assign o_bottom_word = o_bottom_valid ? o_last_word : ~o_last_word;
  // Store on push, free on pop.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bottom_valid <= 1'h0;
      o_last_word <= 4'h0;
      o_pushes <= 0;
    end else if (i_push) begin
      o_bottom_valid <= 1'h1;
      o_last_word <= i_word;
      o_pushes <= o_pushes + 1;
    end else if (i_pop) begin
      o_bottom_valid <= 1'h0;
    end
  end
endmodule // stack_model

/* tb/fifo_array_interlock_tb.sv */
// Self-checking bench for the FIFO slice interlock block with its stack neighbour.
module fifo_array_interlock_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] W_SER = 4'hd;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic stall = 1'h0;
  fifo_interlock_pkg::chain_in_t chain = 10'h2e0;
  logic [3:0] din = 4'h0, sword, bword, lastw, qd;
  logic hsel = 1'h0, hwrite = 1'h0, full_n, output_empty_flag_n, sob, oe, push, pop, tfree, bval, hrdy, hresp, irq;
  logic [7:0] haddr = 8'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata;
  int pushes, mismatches = 0, n_checks = 0, cycles = 0;
  fifo_array_interlock uut (.i_ref_clk(clk), .i_rst(rst), .i_chain(chain), .i_data(din),
    .o_input_full_flag_n(full_n), .o_output_empty_flag_n(output_empty_flag_n), .o_data(qd),
    .o_serial_out_bit(sob), .o_serial_out_oe(oe), .i_stack_top_free(tfree), .o_stack_push(push),
    .o_stack_word(sword), .i_stack_bottom_valid(bval), .i_stack_bottom_word(bword),
    .o_stack_pop(pop), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
    .o_hreadyout(hrdy), .o_hresp(hresp), .o_irq(irq));
  stack_model sm (.i_ref_clk(clk), .i_rst(rst), .i_stall(stall), .i_push(push), .i_word(sword),
    .i_pop(pop), .o_top_free(tfree), .o_bottom_valid(bval), .o_bottom_word(bword),
    .o_last_word(lastw), .o_pushes(pushes));
  always #50 clk = ~clk;
  // A hang counts as a mismatch and closes the run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One single AHB transfer; the address phase is held until ready is seen.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= fifo_interlock_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hrdy !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'h1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'h1, a, d, v);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'h0, a, 32'h0, v);
    chk(name, v, exp);
  endtask
  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Shift clocks are sampled, so each pulse spans two reference edges.
  task automatic pulse_in(input logic b);
    @(posedge clk);
    chain.serial_in_shift_clock <= 1'h1;
    chain.serial_in_bit <= b;
    @(posedge clk) chain.serial_in_shift_clock <= 1'h0;
  endtask
  task automatic pulse_out();
    @(posedge clk) chain.serial_out_shift_clock <= 1'h1;
    @(posedge clk) chain.serial_out_shift_clock <= 1'h0;
  endtask
  // Main sequence: registers first, then the master row slice, then the same slice as a slave.
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    rd_chk("ctrl", fifo_interlock_pkg::OFF_CTRL, 32'h3);
    rd_chk("irq mask", fifo_interlock_pkg::OFF_IRQ_MASK, 32'h0);
    wr(8'h20, 32'hffffffff);
    rd_chk("unmapped", 8'h20, 32'h0);
    chk("okay resp", hresp, 1'h0);
    // With input enable cleared a parallel load must leave the register empty.
    wr(fifo_interlock_pkg::OFF_CTRL, 32'h0);
    @(posedge clk);
    din <= 4'h5;
    chain.parallel_load_strobe <= 1'h1;
    @(posedge clk) chain.parallel_load_strobe <= 1'h0;
    edges(1);
    chk("load disabled", full_n, 1'h1);
    wr(fifo_interlock_pkg::OFF_CTRL, 32'h3);
    $display("test registers done");
    @(posedge clk) chain.init_clear_n <= 1'h0;
    @(posedge clk) chain.init_clear_n <= 1'h1;
    edges(1);
    chk("in full init", full_n, 1'h1);
    rd_chk("status master", fifo_interlock_pkg::OFF_STATUS, 32'h1);
    for (int i = 0; i < 4; i++) pulse_in(W_SER[i]);
    edges(2);
    chk("in full serial", full_n, 1'h0);
    pulse_in(1'h0);
    pulse_in(1'h0);
    @(posedge clk) stall <= 1'h1;
    @(posedge clk) chain.stack_push_request_n <= 1'h0;
    edges(3);
    chk("push stalled", pushes, 0);
    @(posedge clk) stall <= 1'h0;
    edges(4);
    chk("pushes", pushes, 1);
    chk("pushed word", lastw, W_SER);
    chk("master reinit", full_n, 1'h1);
    @(posedge clk) chain.serial_unload_request_n <= 1'h0;
    edges(2);
    chk("out full master", output_empty_flag_n, 1'h1);
    chk("out word", qd, W_SER);
    chk("serial drive", oe, 1'h1);
    @(posedge clk) chain.serial_unload_request_n <= 1'h1;
    rd_chk("out reg", fifo_interlock_pkg::OFF_OUT_WORD, 32'hd);
    for (int i = 0; i < 4; i++) begin
      chk("serial bit", sob, W_SER[i]);
      pulse_out();
      edges(1);
    end
    edges(1);
    chk("out drained", output_empty_flag_n, 1'h0);
    chk("serial released", oe, 1'h0);
    rd_chk("irq status", fifo_interlock_pkg::OFF_IRQ_STAT, 32'h7);
    chk("irq masked", irq, 1'h0);
    wr(fifo_interlock_pkg::OFF_IRQ_MASK, 32'h7);
    edges(1);
    chk("irq raised", irq, 1'h1);
    wr(fifo_interlock_pkg::OFF_IRQ_STAT, 32'h7);
    edges(1);
    chk("irq cleared", irq, 1'h0);
    @(posedge clk);
    din <= 4'h6;
    chain.parallel_load_strobe <= 1'h1;
    chain.stack_push_request_n <= 1'h0;
    edges(4);
    chk("pushes load", pushes, 2);
    chk("reinit postponed", full_n, 1'h0);
    @(posedge clk) chain.parallel_load_strobe <= 1'h0;
    edges(1);
    chk("reinit after load", full_n, 1'h1);
    $display("test master done");
    @(posedge clk);
    chain.stack_push_request_n <= 1'h1;
    chain.init_clear_n <= 1'h0;
    chain.serial_in_chain_enable_n <= 1'h1;
    chain.serial_out_chain_enable_n <= 1'h0;
    @(posedge clk) chain.init_clear_n <= 1'h1;
    rd_chk("status slave", fifo_interlock_pkg::OFF_STATUS, 32'h0);
    @(posedge clk) chain.parallel_unload <= 1'h1;
    edges(4);
    chk("slave out held", output_empty_flag_n, 1'h0);
    @(posedge clk) chain.serial_out_chain_enable_n <= 1'h1;
    edges(1);
    chk("slave out full", output_empty_flag_n, 1'h1);
    chk("slave word", qd, 4'h6);
    @(posedge clk) chain.parallel_unload <= 1'h0;
    @(posedge clk);
    din <= 4'h9;
    chain.parallel_load_strobe <= 1'h1;
    @(posedge clk) chain.parallel_load_strobe <= 1'h0;
    @(posedge clk) chain.stack_push_request_n <= 1'h0;
    edges(4);
    chk("slave pushes", pushes, 3);
    chk("slave waits", full_n, 1'h0);
    @(posedge clk) chain.serial_in_chain_enable_n <= 1'h0;
    edges(1);
    chk("slave reinit", full_n, 1'h1);
    chk("slave pushed", lastw, 4'h9);
    rd_chk("role kept", fifo_interlock_pkg::OFF_STATUS, 32'h0);
    $display("test slave done");
    print_verdict();
  end
endmodule // fifo_array_interlock_tb
bind fifo_array_interlock fifo_array_interlock_monitor mon (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_chain(i_chain), .i_stack_top_free(i_stack_top_free),
  .i_stack_bottom_valid(i_stack_bottom_valid), .o_input_full_flag_n(o_input_full_flag_n),
  .o_output_empty_flag_n(o_output_empty_flag_n), .o_stack_push(o_stack_push),
  .o_stack_pop(o_stack_pop));
